//--- inc/srb_pkg.sv
// Package: opcodes, flag layout and operation codes for the shift unit
package srb_pkg;

  localparam logic [7:0] OP_ROT_LEFT       = 8'h23;
  localparam logic [7:0] OP_ROT_LEFT_CARRY = 8'h33;
  localparam logic [7:0] OP_ROT_RIGHT      = 8'h03;
  localparam logic [7:0] OP_ROT_RIGHT_CARRY = 8'h13;
  localparam logic [7:0] OP_SET_BIT_LEGACY = 8'hD2;
  localparam logic [7:0] OP_SET_CARRY      = 8'hD3;
  localparam logic [7:0] OP_SHORT_JUMP     = 8'h80;
  localparam logic [7:0] OP_ESCAPE         = 8'hA5;
  localparam logic [7:0] OP_EXT_BIT        = 8'hA9;
  localparam logic [3:0] OP_EXT_SET_HI     = 4'hD;
  localparam logic [7:0] OP_SHL            = 8'h3E;
  localparam logic [7:0] OP_SAR            = 8'h0E;
  localparam logic [7:0] OP_SHR_WORD       = 8'h1E;
  localparam logic [7:0] OP_SHR_BYTE       = 8'hD2;
  localparam logic [3:0] SUB_BYTE          = 4'h0;
  localparam logic [3:0] SUB_WORD          = 4'h4;
  localparam logic [15:0] PC_STEP_JUMP     = 16'h0002;
  localparam logic [7:0]  ACC_RESET        = 8'h00;
  localparam logic [15:0] PC_RESET         = 16'h0000;

  typedef struct packed {
    logic carry;
    logic sign;
    logic zero;
  } srb_flags_s;

  typedef struct packed {
    logic        valid;
    logic [7:0]  op0;
    logic [7:0]  op1;
    logic [7:0]  op2;
    logic [7:0]  op3;
  } srb_instr_s;

endpackage : srb_pkg

//--- logic/srb_unit.sv
// Shift, rotate, set-bit and short-jump execution datapath
`timescale 1ns/1ns
// Operation
// - Rotate-left moves accumulator bit 7 to bit 0; carry unchanged.
// - Rotate-left-carry moves bit 7 to carry, old carry to bit 0.
// - Rotate-right moves accumulator bit 0 to bit 7; carry unchanged.
// - Rotate-right-carry moves bit 0 to carry, old carry to bit 7.
// - Set-bit forces carry or an addressed bit to one.
// - Set-bit touches no flag except carry when carry is operand.
// - Set-bit encodings are legacy D2, carry D3, extended A9 D0-D7.
// - In binary mode extended forms need the A5 escape byte first.
// - Short jump adds sign-extended displacement to PC plus two.
// - Jump reach is -128 to +127 around the advanced counter.
// - Left logical shift fills zero, msb shifted out goes to carry.
// - Arithmetic right shift keeps msb, lsb goes to carry.
// - Logical right shift loads zero msb, lsb goes to carry.
// - Shifts update carry, sign, zero for byte and word forms.
module srb_unit #(
  parameter int DATA_W = 8,
  parameter int WORD_W = 16
) (
  input  wire logic               clk_in,
  input  wire logic               srst_in,
  input  wire srb_pkg::srb_instr_s instr_in,
  input  wire logic               binary_mode_in,
  input  wire logic [DATA_W-1:0]  byte_reg_in,
  input  wire logic [WORD_W-1:0]  word_reg_in,
  input  wire logic [WORD_W-1:0]  pc_in,
  input  wire logic               carry_in,
  output logic [DATA_W-1:0]       acc_out,
  output logic [DATA_W-1:0]       byte_result_out,
  output logic                    byte_write_out,
  output logic [WORD_W-1:0]       word_result_out,
  output logic                    word_write_out,
  output logic [3:0]              reg_index_out,
  output logic [WORD_W-1:0]       pc_out,
  output logic                    pc_load_out,
  output logic [7:0]              bit_addr_out,
  output logic                    bit_set_out,
  output srb_pkg::srb_flags_s     flags_out,
  output logic                    illegal_out,
  output logic                    done_out
);

  // ****************************************************************
  // Decode and compute
  // ****************************************************************
  function automatic logic is_zero16(input logic [WORD_W-1:0] v);
    return v == '0;
  endfunction : is_zero16

  logic [DATA_W-1:0] acc;
  logic [DATA_W-1:0] next_acc;
  srb_pkg::srb_flags_s flags;
  srb_pkg::srb_flags_s next_flags;
  logic [DATA_W-1:0] next_byte_result;
  logic              next_byte_write;
  logic [WORD_W-1:0] next_word_result;
  logic              next_word_write;
  logic [3:0]        next_reg_index;
  logic [WORD_W-1:0] next_pc;
  logic              next_pc_load;
  logic [7:0]        next_bit_addr;
  logic              next_bit_set;
  logic              next_illegal;
  logic              next_done;
  logic              cur_carry;

  // Ops after the escape byte shift left by one byte
  logic              esc;
  logic [7:0]        e0;
  logic [7:0]        e1;
  logic [7:0]        e2;
  logic              ext_ok;

  always_comb begin
    esc = instr_in.op0 == srb_pkg::OP_ESCAPE;
    e0 = esc ? instr_in.op1 : instr_in.op0;
    e1 = esc ? instr_in.op2 : instr_in.op1;
    e2 = esc ? instr_in.op3 : instr_in.op2;
    // Binary mode demands the escape; source mode takes it bare
    ext_ok = binary_mode_in ? esc : !esc;
  end

  always_comb begin
    cur_carry = carry_in;
    next_acc = acc;
    next_flags = flags;
    next_byte_result = byte_result_out;
    next_byte_write = 1'b0;
    next_word_result = word_result_out;
    next_word_write = 1'b0;
    next_reg_index = reg_index_out;
    next_pc = pc_out;
    next_pc_load = 1'b0;
    next_bit_addr = bit_addr_out;
    next_bit_set = 1'b0;
    next_illegal = 1'b0;
    next_done = 1'b0;
    if (instr_in.valid) begin
      next_done = 1'b1;
      if (!esc) begin
        case (instr_in.op0)
          srb_pkg::OP_ROT_LEFT: begin
            next_acc = {acc[DATA_W-2:0], acc[DATA_W-1]};
          end
          srb_pkg::OP_ROT_LEFT_CARRY: begin
            next_acc = {acc[DATA_W-2:0], cur_carry};
            next_flags.carry = acc[DATA_W-1];
          end
          srb_pkg::OP_ROT_RIGHT: begin
            next_acc = {acc[0], acc[DATA_W-1:1]};
          end
          srb_pkg::OP_ROT_RIGHT_CARRY: begin
            next_acc = {cur_carry, acc[DATA_W-1:1]};
            next_flags.carry = acc[0];
          end
          srb_pkg::OP_SET_CARRY: begin
            next_flags.carry = 1'b1;
          end
          srb_pkg::OP_SET_BIT_LEGACY: begin
            // Legacy set-bit owns this opcode; the byte shift-right
            // printed with the same code is reached only with escape
            next_bit_addr = instr_in.op1;
            next_bit_set = 1'b1;
          end
          srb_pkg::OP_SHORT_JUMP: begin
            next_pc = pc_in + srb_pkg::PC_STEP_JUMP
                      + {{(WORD_W-8){instr_in.op1[7]}}, instr_in.op1};
            next_pc_load = 1'b1;
          end
          default: ;
        endcase
      end
      if (ext_ok || !esc) begin
        if (e0 == srb_pkg::OP_EXT_BIT && e1[7:4] == srb_pkg::OP_EXT_SET_HI
            && !e1[3] && ext_ok) begin
          next_bit_addr = e2;
          next_bit_set = 1'b1;
        end else if ((e0 == srb_pkg::OP_SHL || e0 == srb_pkg::OP_SAR
                     || e0 == srb_pkg::OP_SHR_WORD
                     || (esc && e0 == srb_pkg::OP_SHR_BYTE))
                     && ext_ok) begin
          next_reg_index = e1[7:4];
          if (e1[3:0] == srb_pkg::SUB_BYTE && e0 != srb_pkg::OP_SHR_WORD) begin
            case (e0)
              srb_pkg::OP_SHL: begin
                next_byte_result = {byte_reg_in[DATA_W-2:0], 1'b0};
                next_flags.carry = byte_reg_in[DATA_W-1];
              end
              srb_pkg::OP_SAR: begin
                next_byte_result = {byte_reg_in[DATA_W-1],
                                    byte_reg_in[DATA_W-1:1]};
                next_flags.carry = byte_reg_in[0];
              end
              default: begin
                next_byte_result = {1'b0, byte_reg_in[DATA_W-1:1]};
                next_flags.carry = byte_reg_in[0];
              end
            endcase
            next_byte_write = 1'b1;
            next_flags.sign = next_byte_result[DATA_W-1];
            next_flags.zero = next_byte_result == '0;
          end else if (e1[3:0] == srb_pkg::SUB_WORD
                       && e0 != srb_pkg::OP_SHR_BYTE) begin
            case (e0)
              srb_pkg::OP_SHL: begin
                next_word_result = {word_reg_in[WORD_W-2:0], 1'b0};
                next_flags.carry = word_reg_in[WORD_W-1];
              end
              srb_pkg::OP_SAR: begin
                next_word_result = {word_reg_in[WORD_W-1],
                                    word_reg_in[WORD_W-1:1]};
                next_flags.carry = word_reg_in[0];
              end
              default: begin
                next_word_result = {1'b0, word_reg_in[WORD_W-1:1]};
                next_flags.carry = word_reg_in[0];
              end
            endcase
            next_word_write = 1'b1;
            next_flags.sign = next_word_result[WORD_W-1];
            next_flags.zero = is_zero16(next_word_result);
          end else begin
            next_illegal = 1'b1;
          end
        end else if (!ext_ok && (e0 == srb_pkg::OP_EXT_BIT
                     || e0 == srb_pkg::OP_SHL || e0 == srb_pkg::OP_SAR
                     || e0 == srb_pkg::OP_SHR_WORD)) begin
          // Extended form seen bare in binary mode: refuse, do not run it
          next_illegal = 1'b1;
        end else if (esc) begin
          next_illegal = 1'b1;
        end
      end else begin
        next_illegal = 1'b1;
      end
      // Rotates drive sign and zero from the new accumulator
      if (!esc && (instr_in.op0 == srb_pkg::OP_ROT_LEFT
          || instr_in.op0 == srb_pkg::OP_ROT_LEFT_CARRY
          || instr_in.op0 == srb_pkg::OP_ROT_RIGHT
          || instr_in.op0 == srb_pkg::OP_ROT_RIGHT_CARRY)) begin
        next_flags.sign = next_acc[DATA_W-1];
        next_flags.zero = next_acc == '0;
      end
    end
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      acc <= srb_pkg::ACC_RESET;
      flags <= '0;
      byte_result_out <= '0;
      byte_write_out <= 1'b0;
      word_result_out <= '0;
      word_write_out <= 1'b0;
      reg_index_out <= '0;
      pc_out <= srb_pkg::PC_RESET;
      pc_load_out <= 1'b0;
      bit_addr_out <= '0;
      bit_set_out <= 1'b0;
      illegal_out <= 1'b0;
      done_out <= 1'b0;
    end else begin
      acc <= next_acc;
      flags <= next_flags;
      byte_result_out <= next_byte_result;
      byte_write_out <= next_byte_write;
      word_result_out <= next_word_result;
      word_write_out <= next_word_write;
      reg_index_out <= next_reg_index;
      pc_out <= next_pc;
      pc_load_out <= next_pc_load;
      bit_addr_out <= next_bit_addr;
      bit_set_out <= next_bit_set;
      illegal_out <= next_illegal;
      done_out <= next_done;
    end
  end

  assign acc_out = acc;
  assign flags_out = flags;

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (srst_in);

  logic plain;
  assign plain = instr_in.valid && !esc;

  rot_left_a: assert property (plain && instr_in.op0 == 8'h23 |=>
    acc == {$past(acc[6:0]), $past(acc[7])}
    && flags.carry == $past(flags.carry)) else $error("rotate left wrong");
  rot_left_carry_a: assert property (plain && instr_in.op0 == 8'h33 |=>
    acc == {$past(acc[6:0]), $past(carry_in)} && flags.carry == $past(acc[7]))
    else $error("rotate left carry wrong");
  rot_right_a: assert property (plain && instr_in.op0 == 8'h03 |=>
    acc == {$past(acc[0]), $past(acc[7:1])}) else $error("rotate right wrong");
  rot_right_carry_a: assert property (plain && instr_in.op0 == 8'h13 |=>
    acc[7] == $past(carry_in) && flags.carry == $past(acc[0]))
    else $error("rotate right carry wrong");
  set_carry_a: assert property (plain && instr_in.op0 == 8'hD3 |=>
    flags.carry && $stable(flags.zero) && $stable(acc))
    else $error("set carry wrong");
  jump_target_a: assert property (plain && instr_in.op0 == 8'h80 |=>
    pc_load_out && pc_out == $past(pc_in) + 16'h0002
    + {{8{$past(instr_in.op1[7])}}, $past(instr_in.op1)})
    else $error("jump target wrong");
  escape_need_a: assert property (instr_in.valid && binary_mode_in && !esc
    && instr_in.op0 == 8'h3E |=> illegal_out && !byte_write_out)
    else $error("missing escape accepted");
  shift_zero_a: assert property (byte_write_out || word_write_out |->
    flags.zero == (byte_write_out ? byte_result_out == '0
                                  : word_result_out == '0))
    else $error("zero flag wrong");
  shl_carry_a: assert property (instr_in.valid && ext_ok && e0 == 8'h3E
    && e1[3:0] == 4'h4 |=> flags.carry == $past(word_reg_in[15])
    && word_result_out[0] == 1'b0) else $error("left shift carry wrong");
  bit_flags_a: assert property (plain && instr_in.op0 == 8'hD2 |=>
    bit_set_out && bit_addr_out == $past(instr_in.op1) && $stable(flags))
    else $error("set bit touched flags");
  word_sar_a: assert property (instr_in.valid && ext_ok && e0 == 8'h0E
    && e1[3:0] == 4'h4 |=> word_result_out[15] == $past(word_reg_in[15])
    && flags.carry == $past(word_reg_in[0])) else $error("word sar wrong");
  rot_flags_a: assert property (plain && instr_in.op0 == 8'h03 |=>
    flags.sign == acc[7] && flags.zero == (acc == 8'h00))
    else $error("rotate flags wrong");
  byte_shr_a: assert property (instr_in.valid && esc && ext_ok
    && e0 == 8'hD2 && e1[3:0] == 4'h0 |=> byte_result_out[7] == 1'b0
    && flags.carry == $past(byte_reg_in[0])) else $error("byte shr wrong");

  jump_c: cover property (pc_load_out);
  word_c: cover property (word_write_out);
  bit_c: cover property (bit_set_out);
  illegal_c: cover property (illegal_out);
  shift_c: cover property (byte_write_out);

endmodule : srb_unit

//--- dv/tb_srb_unit.sv
// Self-checking bench for the shift, rotate, set-bit and jump unit
`timescale 1ns/1ns
module tb_srb_unit;
  logic                clk      = 1'b0;
  logic                srst     = 1'b1;
  srb_pkg::srb_instr_s instr    = '0;
  logic                bin_mode = 1'b1;
  logic [15:0]         opnd     = 16'h0000;
  logic                cin      = 1'b0;
  logic [7:0]          acc, byte_res, bit_addr;
  logic [15:0]         word_res, pc_res;
  logic [3:0]          reg_idx;
  logic                byte_wr, word_wr, pc_ld, bit_set, illegal, done;
  logic [4:0]          strb;
  srb_pkg::srb_flags_s flags;
  logic [7:0]          ld = 8'hC5;
  logic [7:0]          rel [4] = '{8'h21, 8'h80, 8'h7F, 8'hFE};
  logic [15:0]         tgt [4] = '{16'h0123, 16'h0082, 16'h0181, 16'h0100};
  int                  n_fail = 0;
  int                  check_count = 0;

  always #25 clk = ~clk;

  srb_unit dut (
    .clk_in(clk), .srst_in(srst), .instr_in(instr),
    .binary_mode_in(bin_mode), .byte_reg_in(opnd[7:0]),
    .word_reg_in(opnd), .pc_in(opnd), .carry_in(cin),
    .acc_out(acc), .byte_result_out(byte_res), .byte_write_out(byte_wr),
    .word_result_out(word_res), .word_write_out(word_wr),
    .reg_index_out(reg_idx), .pc_out(pc_res), .pc_load_out(pc_ld),
    .bit_addr_out(bit_addr), .bit_set_out(bit_set), .flags_out(flags),
    .illegal_out(illegal), .done_out(done));

  // ****************************************
  // Access tasks
  // ****************************************
  task automatic check(input string what, input logic [15:0] seen,
                       input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask : check

  // Strobes are captured in the answer cycle, then must fall one cycle on
  task automatic exec(input logic [31:0] ops, input logic bm,
                      input logic [15:0] val, input logic c);
    @(posedge clk);
    instr    <= {1'b1, ops};
    bin_mode <= bm;
    opnd     <= val;
    cin      <= c;
    @(posedge clk);
    instr.valid <= 1'b0;
    #1;
    strb = {byte_wr, word_wr, pc_ld, bit_set, illegal};
    check("done", {15'h0, done}, 16'h0001);
    @(posedge clk);
    #1;
    check("strobes low", {10'h0, byte_wr, word_wr, pc_ld, bit_set, illegal,
          done}, 16'h0000);
  endtask : exec

  task automatic expect_acc(input logic [7:0] a, input logic [2:0] f);
    check("acc", {8'h00, acc}, {8'h00, a});
    check("flags", {13'h0, flags}, {13'h0, f});
  endtask : expect_acc

  task automatic sh(input logic [31:0] ops, input logic bm,
                    input logic [15:0] val, input logic [15:0] res,
                    input logic [2:0] f, input logic wide);
    exec(ops, bm, val, 1'b0);
    check("shift strobes", {11'h0, strb}, wide ? 16'h0008 : 16'h0010);
    check("shift result", wide ? word_res : {8'h00, byte_res}, res);
    check("reg index", {12'h0, reg_idx}, 16'h0005);
    expect_acc(8'h00, f);
  endtask : sh

  task automatic report_and_stop();
    $display("checks %0d, mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : report_and_stop

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    repeat (10) @(posedge clk);
    srst <= 1'b0;
    #1;
    expect_acc(8'h00, 3'b000);
    // No load port: build the accumulator by rotating carry bits in
    for (int i = 7; i >= 0; i--) exec({srb_pkg::OP_ROT_LEFT_CARRY, 24'h0},
                                      1'b1, 16'h0000, ld[i]);
    expect_acc(8'hC5, 3'b010);
    exec({srb_pkg::OP_ROT_LEFT, 24'h0}, 1'b1, 16'h0000, 1'b1);
    expect_acc(8'h8B, 3'b010);
    exec({srb_pkg::OP_ROT_RIGHT, 24'h0}, 1'b1, 16'h0000, 1'b1);
    expect_acc(8'hC5, 3'b010);
    exec({srb_pkg::OP_ROT_RIGHT_CARRY, 24'h0}, 1'b1, 16'h0000, 1'b0);
    expect_acc(8'h62, 3'b100);
    exec({srb_pkg::OP_ROT_LEFT, 24'h0}, 1'b1, 16'h0000, 1'b0);
    expect_acc(8'hC4, 3'b110);
    for (int i = 0; i < 8; i++) exec({srb_pkg::OP_ROT_LEFT_CARRY, 24'h0},
                                     1'b1, 16'h0000, 1'b0);
    expect_acc(8'h00, 3'b001);
    exec(32'hD3000000, 1'b1, 16'h0000, 1'b0);
    expect_acc(8'h00, 3'b101);
    exec(32'hD25A0000, 1'b1, 16'h0000, 1'b0);
    check("set strobes", {11'h0, strb}, 16'h0002);
    check("bit addr", {8'h00, bit_addr}, 16'h005A);
    exec(32'hA5A9D377, 1'b1, 16'h0000, 1'b0);
    check("ext set binary", {3'h0, strb, bit_addr}, 16'h0277);
    exec(32'hA9D36600, 1'b0, 16'h0000, 1'b0);
    check("ext set source", {3'h0, strb, bit_addr}, 16'h0266);
    exec(32'hA9D35500, 1'b1, 16'h0000, 1'b0);
    check("no escape", {3'h0, strb, bit_addr}, 16'h0166);
    exec(32'hA5A9D344, 1'b0, 16'h0000, 1'b0);
    check("stray escape", {3'h0, strb, bit_addr}, 16'h0166);
    exec(32'h3E500000, 1'b1, 16'h00C5, 1'b0);
    check("bare shift", {11'h0, strb}, 16'h0001);
    expect_acc(8'h00, 3'b101);
    for (int i = 0; i < 4; i++) begin
      exec({srb_pkg::OP_SHORT_JUMP, rel[i], 16'h0}, 1'b1, 16'h0100, 1'b0);
      check("jump strobes", {11'h0, strb}, 16'h0004);
      check("jump target", pc_res, tgt[i]);
      expect_acc(8'h00, 3'b101);
    end
    sh(32'hA53E5000, 1'b1, 16'h00C5, 16'h008A, 3'b110, 1'b0);
    sh(32'hA50E5000, 1'b1, 16'h00C5, 16'h00E2, 3'b110, 1'b0);
    sh(32'hA5D25000, 1'b1, 16'h00C5, 16'h0062, 3'b100, 1'b0);
    sh(32'hA53E5400, 1'b1, 16'h8001, 16'h0002, 3'b100, 1'b1);
    sh(32'hA50E5400, 1'b1, 16'h8001, 16'hC000, 3'b110, 1'b1);
    sh(32'hA51E5400, 1'b1, 16'h0001, 16'h0000, 3'b101, 1'b1);
    sh(32'h3E500000, 1'b0, 16'h0080, 16'h0000, 3'b101, 1'b0);
    sh(32'h1E540000, 1'b0, 16'h7FFE, 16'h3FFF, 3'b000, 1'b1);
    // Second reset mid-run must clear the state again
    @(posedge clk);
    srst <= 1'b1;
    @(posedge clk);
    srst <= 1'b0;
    #1;
    expect_acc(8'h00, 3'b000);
    check("pc after reset", pc_res, 16'h0000);
    report_and_stop();
  end
endmodule : tb_srb_unit
